/* pkg/clock_gen_regs.svh */
`ifndef CLOCK_GEN_REGS_SVH
`define CLOCK_GEN_REGS_SVH

`define CG_ADDR_W 12
`define CG_DATA_W 8

`define CG_ADDR_PORT_CFG 12'h000
`define CG_ADDR_READBACK 12'h004
`define CG_ADDR_VER_LO 12'h005
`define CG_ADDR_VER_HI 12'h006
`define CG_ADDR_PUMP 12'h010
`define CG_ADDR_R_LO 12'h011
`define CG_ADDR_R_HI 12'h012
`define CG_ADDR_A 12'h013
`define CG_ADDR_B_LO 12'h014
`define CG_ADDR_B_HI 12'h015

`define CG_IDX_W 4
`define CG_IDX_VER_LO 4'h0
`define CG_IDX_VER_HI 4'h1
`define CG_IDX_PUMP 4'h2
`define CG_IDX_R_LO 4'h3
`define CG_IDX_R_HI 4'h4
`define CG_IDX_A 4'h5
`define CG_IDX_B_LO 4'h6
`define CG_IDX_B_HI 4'h7
`define CG_IDX_MISS 4'hF
`define CG_BANK_N 8

`define CG_MASK_FULL 8'hFF
`define CG_MASK_R_HI 8'h3F
`define CG_MASK_A 8'h3F
`define CG_MASK_B_HI 8'h1F
`define CG_R_HI_BITS 6
`define CG_A_BITS 6
`define CG_B_HI_BITS 5

`define CG_PC_SDO_HI 7
`define CG_PC_LSB_HI 6
`define CG_PC_SRST_HI 5
`define CG_PC_SRST_LO 2
`define CG_PC_LSB_LO 1
`define CG_PC_SDO_LO 0
`define CG_RB_ACTIVE 0

`define CG_RESET_BYTE 8'h00
`define CG_SRST_CNT_W 4
`define CG_SRST_CYCLES 4'h8
`define CG_SRST_LAST 4'h7
`define CG_SRST_DONE 4'h0
`define CG_SRST_STEP 4'h1

`endif

/* pkg/clock_gen_pkg.sv */
`include "clock_gen_regs.svh"

package clock_gen_pkg;

	typedef logic [`CG_DATA_W-1:0] byte_t;

	typedef struct packed {
		logic [`CG_BANK_N-1:0][`CG_DATA_W-1:0] bank;
		logic [`CG_BANK_N-1:0][`CG_DATA_W-1:0] active;
		logic sdo_active;
		logic lsb_first;
		logic readback_active;
		logic [`CG_DATA_W-1:0] rdata;
		logic rd_valid;
	} regs_state_t;

	typedef enum logic [1:0] {
		SR_IDLE = 2'b01,
		SR_BUSY = 2'b10
	} soft_state_t;

	typedef struct packed {
		soft_state_t state;
		logic [`CG_SRST_CNT_W-1:0] count;
	} soft_reg_t;

endpackage : clock_gen_pkg

/* rtl/soft_reset_ctrl.sv */
`timescale 1ns/1ns
`include "clock_gen_regs.svh"

module soft_reset_ctrl
(
	input wire logic clk,
	input wire logic reset,
	input wire logic start,
	output logic busy
);

	clock_gen_pkg::soft_reg_t cur_reg;
	clock_gen_pkg::soft_reg_t cur_next;

	always_comb
	begin
		cur_next = cur_reg;
		case (cur_reg.state)
			clock_gen_pkg::SR_IDLE:
			begin
				cur_next.count = `CG_SRST_LAST;
			end
			clock_gen_pkg::SR_BUSY:
			begin
				if (cur_reg.count == `CG_SRST_DONE)
				begin
					cur_next.state = clock_gen_pkg::SR_IDLE; // RULE7
				end
				else
				begin
					cur_next.count = cur_reg.count - `CG_SRST_STEP;
				end
			end
			default:
			begin
				cur_next.state = clock_gen_pkg::SR_IDLE;
			end
		endcase
		// A new request in the finishing cycle restarts the reset.
		if (start)
		begin
			cur_next.state = clock_gen_pkg::SR_BUSY;
			cur_next.count = `CG_SRST_LAST;
		end
	end

	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			cur_reg.state <= clock_gen_pkg::SR_IDLE;
			cur_reg.count <= `CG_SRST_LAST;
		end
		else
		begin
			cur_reg <= cur_next;
		end
	end

	assign busy = (cur_reg.state == clock_gen_pkg::SR_BUSY);

	a_soft_len: assert property (@(posedge clk) disable iff (reset) // RULE7
		$fell(busy) |-> $past(busy, 8))
		else $error("Soft reset ended early.");

	a_soft_run: assert property (@(posedge clk) disable iff (reset) // RULE7
		start |=> busy [*8] ##1 (!busy || $past(start, 1)))
		else $error("Soft reset did not last its length.");

endmodule : soft_reset_ctrl

/* rtl/clock_gen_config_registers.sv */
`timescale 1ns/1ns
`include "clock_gen_regs.svh"

// Functional notes
// RULE1 - Writes to addresses outside the register map change no state.
// RULE2 - Host should write zero to unused addresses and unused fields.
// RULE3 - Reference divider is 14 bits: low byte, then six bits above.
// RULE4 - Feedback B divider is 13 bits; low byte at the next-to-last counter register.
// RULE5 - B divider upper five bits sit low in the following register.
// RULE6 - Sixteen-bit configuration version: low byte first, high byte second.
// RULE7 - Soft reset bits self-clear when done and read mirrored at 5 and 2.

module clock_gen_config_registers
(
	input wire logic clk,
	input wire logic reset,
	input wire logic [`CG_ADDR_W-1:0] reg_addr,
	input wire logic reg_wr,
	input wire logic [`CG_DATA_W-1:0] reg_wdata,
	input wire logic reg_rd,
	input wire logic io_update,
	output logic [`CG_DATA_W-1:0] reg_rdata,
	output logic reg_rd_valid,
	output logic soft_reset_busy,
	output logic sdo_active,
	output logic lsb_first,
	output logic [`CG_DATA_W-1:0] phase_detector_pump_ctrl,
	output logic [15:0] config_version,
	output logic [13:0] ref_divider,
	output logic [5:0] a_divider,
	output logic [12:0] b_divider
);

	clock_gen_pkg::regs_state_t cur_reg;
	clock_gen_pkg::regs_state_t cur_next;
	logic soft_start;
	logic sr_busy;
	logic [`CG_IDX_W-1:0] wr_idx;
	logic [`CG_IDX_W-1:0] rd_idx;

	function automatic logic [`CG_IDX_W-1:0] bank_index
	(
		input logic [`CG_ADDR_W-1:0] addr
	);
		logic [`CG_IDX_W-1:0] idx;
		idx = `CG_IDX_MISS;
		if (addr == `CG_ADDR_VER_LO)
			idx = `CG_IDX_VER_LO;
		else if (addr == `CG_ADDR_VER_HI)
			idx = `CG_IDX_VER_HI;
		else if (addr == `CG_ADDR_PUMP)
			idx = `CG_IDX_PUMP;
		else if (addr == `CG_ADDR_R_LO)
			idx = `CG_IDX_R_LO;
		else if (addr == `CG_ADDR_R_HI)
			idx = `CG_IDX_R_HI;
		else if (addr == `CG_ADDR_A)
			idx = `CG_IDX_A;
		else if (addr == `CG_ADDR_B_LO)
			idx = `CG_IDX_B_LO;
		else if (addr == `CG_ADDR_B_HI)
			idx = `CG_IDX_B_HI;
		return idx;
	endfunction : bank_index

	// Unused upper bits are never stored, so they always read as zero.
	function automatic logic [`CG_DATA_W-1:0] field_mask
	(
		input logic [`CG_IDX_W-1:0] idx
	);
		logic [`CG_DATA_W-1:0] mask;
		mask = `CG_MASK_FULL;
		if (idx == `CG_IDX_R_HI)
			mask = `CG_MASK_R_HI;
		else if (idx == `CG_IDX_A)
			mask = `CG_MASK_A;
		else if (idx == `CG_IDX_B_HI)
			mask = `CG_MASK_B_HI;
		return mask;
	endfunction : field_mask

	function automatic logic is_mapped
	(
		input logic [`CG_ADDR_W-1:0] addr
	);
		return (addr == `CG_ADDR_PORT_CFG) || (addr == `CG_ADDR_READBACK)
			|| (bank_index(addr) != `CG_IDX_MISS);
	endfunction : is_mapped

	assign wr_idx = bank_index(reg_addr);
	assign rd_idx = bank_index(reg_addr);
	assign soft_start = reg_wr && (reg_addr == `CG_ADDR_PORT_CFG)
		&& (reg_wdata[`CG_PC_SRST_HI] || reg_wdata[`CG_PC_SRST_LO]);

	soft_reset_ctrl u_soft_reset
	(
		.clk(clk),
		.reset(reset),
		.start(soft_start),
		.busy(sr_busy)
	);

	always_comb
	begin
		cur_next = cur_reg;
		cur_next.rd_valid = 1'b0;
		if (sr_busy)
		begin
			// Every register returns to its default while the reset runs.
			for (int i = 0; i < `CG_BANK_N; i++)
			begin
				cur_next.bank[i] = `CG_RESET_BYTE;
				cur_next.active[i] = `CG_RESET_BYTE;
			end
			cur_next.sdo_active = 1'b0;
			cur_next.lsb_first = 1'b0;
			cur_next.readback_active = 1'b0;
		end
		else
		begin
			if (reg_wr)
			begin
				// Either copy of a mirrored field sets it, so bit order is moot.
				if (reg_addr == `CG_ADDR_PORT_CFG)
				begin
					cur_next.sdo_active = reg_wdata[`CG_PC_SDO_HI]
						| reg_wdata[`CG_PC_SDO_LO];
					cur_next.lsb_first = reg_wdata[`CG_PC_LSB_HI]
						| reg_wdata[`CG_PC_LSB_LO];
				end
				else if (reg_addr == `CG_ADDR_READBACK)
				begin
					cur_next.readback_active = reg_wdata[`CG_RB_ACTIVE];
				end
				else if (wr_idx != `CG_IDX_MISS) // RULE1
				begin
					cur_next.bank[wr_idx[2:0]] = reg_wdata & field_mask(wr_idx); // RULE3
				end
			end
			// A write in the same cycle as the update takes effect at once.
			if (io_update)
			begin
				cur_next.active = cur_next.bank;
			end
		end
		if (reg_rd)
		begin
			cur_next.rd_valid = 1'b1;
			cur_next.rdata = `CG_RESET_BYTE;
			if (reg_addr == `CG_ADDR_PORT_CFG)
			begin
				cur_next.rdata[`CG_PC_SDO_HI] = cur_reg.sdo_active;
				cur_next.rdata[`CG_PC_SDO_LO] = cur_reg.sdo_active;
				cur_next.rdata[`CG_PC_LSB_HI] = cur_reg.lsb_first;
				cur_next.rdata[`CG_PC_LSB_LO] = cur_reg.lsb_first;
				cur_next.rdata[`CG_PC_SRST_HI] = sr_busy; // RULE7
				cur_next.rdata[`CG_PC_SRST_LO] = sr_busy; // RULE7
			end
			else if (reg_addr == `CG_ADDR_READBACK)
			begin
				cur_next.rdata[`CG_RB_ACTIVE] = cur_reg.readback_active;
			end
			else if (rd_idx != `CG_IDX_MISS)
			begin
				if (cur_reg.readback_active)
					cur_next.rdata = cur_reg.active[rd_idx[2:0]];
				else
					cur_next.rdata = cur_reg.bank[rd_idx[2:0]];
			end
		end
	end

	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			cur_reg <= '0;
		end
		else
		begin
			cur_reg <= cur_next;
		end
	end

	assign reg_rdata = cur_reg.rdata;
	assign reg_rd_valid = cur_reg.rd_valid;
	assign soft_reset_busy = sr_busy;
	assign sdo_active = cur_reg.sdo_active;
	assign lsb_first = cur_reg.lsb_first;
	assign phase_detector_pump_ctrl = cur_reg.active[`CG_IDX_PUMP];
	assign config_version = {cur_reg.active[`CG_IDX_VER_HI],
		cur_reg.active[`CG_IDX_VER_LO]}; // RULE6
	assign ref_divider = {cur_reg.active[`CG_IDX_R_HI][`CG_R_HI_BITS-1:0],
		cur_reg.active[`CG_IDX_R_LO]}; // RULE3
	assign a_divider = cur_reg.active[`CG_IDX_A][`CG_A_BITS-1:0];
	assign b_divider = {cur_reg.active[`CG_IDX_B_HI][`CG_B_HI_BITS-1:0],
		cur_reg.active[`CG_IDX_B_LO]}; // RULE4 RULE5

	a_unmapped_write: assert property (@(posedge clk) disable iff (reset) // RULE1
		(reg_wr && !is_mapped(reg_addr) && !sr_busy && !io_update)
		|=> (cur_reg.bank == $past(cur_reg.bank))
		&& (cur_reg.active == $past(cur_reg.active)))
		else $error("Unmapped write changed a register.");

	a_ref_divider: assert property (@(posedge clk) disable iff (reset) // RULE3
		(io_update && !sr_busy && !reg_wr)
		|=> ref_divider == $past({cur_reg.bank[`CG_IDX_R_HI][5:0],
		cur_reg.bank[`CG_IDX_R_LO]}))
		else $error("Reference divider not loaded from its two bytes.");

	a_ref_high_zero: assert property (@(posedge clk) disable iff (reset) // RULE3
		(reg_rd && reg_addr == `CG_ADDR_R_HI) |=> reg_rdata[7:6] == 2'h0)
		else $error("Unused reference divider bits read nonzero.");

	a_b_divider: assert property (@(posedge clk) disable iff (reset) // RULE4
		(io_update && !sr_busy && !reg_wr)
		|=> b_divider == $past({cur_reg.bank[`CG_IDX_B_HI][4:0],
		cur_reg.bank[`CG_IDX_B_LO]}))
		else $error("B divider not loaded from its two bytes.");

	a_b_high_field: assert property (@(posedge clk) disable iff (reset) // RULE5
		(reg_wr && reg_addr == `CG_ADDR_B_HI && !sr_busy)
		|=> cur_reg.bank[`CG_IDX_B_HI] == {3'h0, $past(reg_wdata[4:0])})
		else $error("B divider high byte field misplaced.");

	a_version_order: assert property (@(posedge clk) disable iff (reset) // RULE6
		(reg_wr && reg_addr == `CG_ADDR_VER_LO && !sr_busy) ##1 io_update
		&& !sr_busy && !reg_wr |=> config_version[7:0] == $past(reg_wdata, 2))
		else $error("Version low byte not in low half.");

	a_soft_mirror: assert property (@(posedge clk) disable iff (reset) // RULE7
		(reg_rd && reg_addr == `CG_ADDR_PORT_CFG)
		|=> reg_rd_valid && reg_rdata[5] == reg_rdata[2]
		&& reg_rdata[5] == $past(sr_busy))
		else $error("Soft reset bits not mirrored.");

	a_soft_clears: assert property (@(posedge clk) disable iff (reset) // RULE7
		soft_start |-> ##[1:9] (cur_reg.sdo_active == 1'b0) ##[1:9] !sr_busy)
		else $error("Soft reset did not clear itself.");

endmodule : clock_gen_config_registers

/* tb/host_model.sv */
`timescale 1ns/1ns
`include "clock_gen_regs.svh"

module host_model
(
	input wire logic clk,
	output logic [`CG_ADDR_W-1:0] reg_addr,
	output logic reg_wr,
	output logic [`CG_DATA_W-1:0] reg_wdata,
	output logic reg_rd,
	output logic io_update,
	input wire logic [`CG_DATA_W-1:0] reg_rdata,
	input wire logic reg_rd_valid
);
	initial
	begin
		reg_addr = 12'h000;
		reg_wr = 1'b0;
		reg_wdata = 8'h00;
		reg_rd = 1'b0;
		io_update = 1'b0;
	end

	// Released lines show the inverse, so a stale value is never trusted.
	task wr(input logic [11:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
		reg_addr <= ~a;
		reg_wdata <= ~d;
	endtask : wr

	task rd(input logic [11:0] a, output logic [7:0] d, output logic v);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		reg_addr <= ~a;
		#1;
		d = reg_rdata;
		v = reg_rd_valid;
	endtask : rd

	// Update lands in the cycle right after the write, not in the write's own cycle.
	task wr_upd(input logic [11:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
		reg_addr <= ~a;
		reg_wdata <= ~d;
		io_update <= 1'b1;
		@(posedge clk);
		io_update <= 1'b0;
		#1;
	endtask : wr_upd

	task upd;
		@(posedge clk);
		io_update <= 1'b1;
		@(posedge clk);
		io_update <= 1'b0;
		#1;
	endtask : upd
endmodule : host_model

/* tb/clock_gen_config_registers_bench.sv */
`timescale 1ns/1ns
`include "clock_gen_regs.svh"

module clock_gen_config_registers_bench;
	logic clk;
	logic reset;
	logic [11:0] reg_addr;
	logic reg_wr;
	logic [7:0] reg_wdata;
	logic reg_rd;
	logic io_update;
	logic [7:0] reg_rdata;
	logic reg_rd_valid;
	logic soft_reset_busy;
	logic sdo_active;
	logic lsb_first;
	logic [7:0] phase_detector_pump_ctrl;
	logic [15:0] config_version;
	logic [13:0] ref_divider;
	logic [5:0] a_divider;
	logic [12:0] b_divider;
	int mismatches = 0;
	int n_tests = 0;
	int n;
	logic [11:0] map [10] = '{12'h000, 12'h004, 12'h005, 12'h006, 12'h010,
		12'h011, 12'h012, 12'h013, 12'h014, 12'h015};

	clock_gen_config_registers u_clock_gen_config_registers (.clk(clk),
		.reset(reset), .reg_addr(reg_addr), .reg_wr(reg_wr),
		.reg_wdata(reg_wdata), .reg_rd(reg_rd), .io_update(io_update),
		.reg_rdata(reg_rdata), .reg_rd_valid(reg_rd_valid),
		.soft_reset_busy(soft_reset_busy), .sdo_active(sdo_active),
		.lsb_first(lsb_first),
		.phase_detector_pump_ctrl(phase_detector_pump_ctrl),
		.config_version(config_version), .ref_divider(ref_divider),
		.a_divider(a_divider), .b_divider(b_divider));

	host_model u_host_model (.clk(clk), .reg_addr(reg_addr),
		.reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd),
		.io_update(io_update), .reg_rdata(reg_rdata),
		.reg_rd_valid(reg_rd_valid));

	initial
		clk = 1'b0;
	always #2 clk = ~clk;

	task tally_and_finish;
		$display("checks %0d mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : tally_and_finish

	task chk(input string name, input logic [15:0] e, input logic [15:0] g);
		n_tests++;
		if (g !== e)
		begin
			mismatches++;
			$display("[ERR] %s expected %h seen %h", name, e, g);
		end
	endtask : chk

	task rchk(input logic [11:0] a, input logic [7:0] e);
		logic [7:0] d;
		logic v;
		u_host_model.rd(a, d, v);
		chk("rd_valid", 16'h0001, {15'h0000, v});
		chk("rdata", {8'h00, e}, {8'h00, d});
	endtask : rchk

	initial
	begin
		repeat (2000) @(posedge clk);
		mismatches++;
		tally_and_finish;
	end

	initial
	begin
		reset = 1'b1;
		repeat (8) @(posedge clk);
		reset <= 1'b0;
		foreach (map[i])
			rchk(map[i], 8'h00);
		u_host_model.wr(12'h007, 8'h00);
		u_host_model.wr(12'h011, 8'hA5);
		u_host_model.wr(12'h012, 8'hFF);
		u_host_model.wr(12'h013, 8'hFF);
		u_host_model.wr(12'h014, 8'h5A);
		u_host_model.wr(12'h015, 8'hFF);
		u_host_model.wr(12'h005, 8'h34);
		u_host_model.wr(12'h006, 8'h12);
		u_host_model.wr(12'h100, 8'hFF);
		u_host_model.wr(12'h00F, 8'hFF);
		rchk(12'h100, 8'h00);
		rchk(12'h00F, 8'h00);
		rchk(12'h012, 8'h3F);
		rchk(12'h015, 8'h1F);
		chk("ref_divider", 16'h0000, {2'b00, ref_divider});
		u_host_model.wr(12'h010, 8'hC3);
		u_host_model.upd();
		chk("ref_divider", 16'h3FA5, {2'b00, ref_divider});
		chk("b_divider", 16'h1F5A, {3'b000, b_divider});
		chk("config_version", 16'h1234, config_version);
		chk("a_divider", 16'h003F, {10'h000, a_divider});
		chk("pump", 16'h00C3, {8'h00, phase_detector_pump_ctrl});
		u_host_model.wr_upd(12'h005, 8'h77);
		chk("config_version", 16'h1277, config_version);
		u_host_model.wr(12'h011, 8'h00);
		u_host_model.wr(12'h004, 8'h01);
		rchk(12'h004, 8'h01);
		rchk(12'h011, 8'hA5);
		u_host_model.wr(12'h000, 8'h81);
		#1;
		chk("sdo_lsb", 16'h0002, {14'h0000, sdo_active, lsb_first});
		rchk(12'h000, 8'h81);
		u_host_model.wr(12'h000, 8'h02);
		#1;
		chk("sdo_lsb", 16'h0001, {14'h0000, sdo_active, lsb_first});
		rchk(12'h000, 8'h42);
		u_host_model.wr(12'h000, 8'h24);
		#1;
		n = 0;
		while (soft_reset_busy === 1'b1 && n < 20)
		begin
			n++;
			@(posedge clk);
			#1;
		end
		chk("busy_cycles", 16'h0008, n[15:0]);
		rchk(12'h000, 8'h00);
		rchk(12'h011, 8'h00);
		chk("ref_divider", 16'h0000, {2'b00, ref_divider});
		u_host_model.wr(12'h000, 8'h04);
		rchk(12'h000, 8'h24);
		u_host_model.wr(12'h011, 8'h55);
		repeat (10) @(posedge clk);
		rchk(12'h011, 8'h00);
		tally_and_finish;
	end
endmodule : clock_gen_config_registers_bench
